// File: rtl/kwi_regs.svh
// Register map, field positions and reset values of the keypad wake block.
//
// Summary of operation
// - Seven keypad inputs, numbered six down to zero, share pins with port lines.
// - Inputs three to zero always trigger on falling edges or low levels.
// - Inputs six to four each select rising/high or falling/low triggering.
// - An enabled rising-polarity input with its pull on gets a pulldown.
// - A keypad trigger wakes the processor from stop mode and from wait mode.
// - Bit 7 of the status/control and pin enable registers reads zero.
// - Polarity bits 6:4 pick 0 for falling/low and 1 for rising/high.
// - Pending flag bit 3 sets when a trigger is seen on any enabled input.
// - Writing 1 to the acknowledge bit clears the pending flag.
// - The acknowledge bit 2 is write-only and always reads zero.
// - In edge-and-level mode an asserted enabled input holds the flag set.
// - Interrupt enable bit 1 requests an interrupt while the flag is set.
// - Mode bit 0 picks edge-only (0) or edge-and-level (1) for all inputs.
// - A pin enable bit of 1 joins the pin to the block; 0 ignores it.
// - An edge is deasserted in one cycle and asserted in the next.
// - In stop mode the inputs act as level-sensitive wake sources.
`ifndef KWI_REGS_SVH
`define KWI_REGS_SVH

`define KWI_ADDR_W 8
`define KWI_DATA_W 32
`define KWI_NPINS 7
`define KWI_REG_W 8

// Byte offsets on the APB.
`define KWI_OFF_SC 8'h00
`define KWI_OFF_PE 8'h04
`define KWI_OFF_IST 8'h08
`define KWI_OFF_IMSK 8'h0c

// Status/control field positions.
`define KWI_POL_MSB 6
`define KWI_POL_LSB 4
`define KWI_PEND_BIT 3
`define KWI_ACK_BIT 2
`define KWI_IE_BIT 1
`define KWI_MODE_BIT 0

// Inputs 3:0 have no polarity bit and are tied to falling/low.
`define KWI_FIXED_POL 4'h0

// Interrupt status and mask layout.
`define KWI_IST_W 2
`define KWI_IST_PEND 0
`define KWI_IST_WAKE 1

// Reset values.
`define KWI_RST_POL 3'h0
`define KWI_RST_PE 7'h00
`define KWI_RST_IST 2'h0
`define KWI_RST_PREV 7'h7f
`define KWI_RST_DATA 32'h0000_0000

`endif

// File: rtl/kwi_pkg.sv
// Types shared by the keypad wake block.
package kwi_pkg;
   typedef logic [6:0] kwi_pins_t;
   typedef enum logic [2:0] {
      KWI_SEL_SC,
      KWI_SEL_PE,
      KWI_SEL_IST,
      KWI_SEL_IMSK,
      KWI_SEL_NONE
   } kwi_sel_t;
endpackage : kwi_pkg

// File: rtl/kwi_det_if.sv
// Signals between the register logic and the input detector.
`timescale 1ns/1ps
interface kwi_det_if;
   kwi_pkg::kwi_pins_t pin_in;
   kwi_pkg::kwi_pins_t pin_en;
   kwi_pkg::kwi_pins_t pol;
   logic stop;
   logic edge_any;
   logic level_any;
   modport ctl (
      output pin_in,
      output pin_en,
      output pol,
      output stop,
      input edge_any,
      input level_any
   );
   modport det (
      input pin_in,
      input pin_en,
      input pol,
      input stop,
      output edge_any,
      output level_any
   );
endinterface : kwi_det_if

// File: rtl/kwi_detect.sv
// Per-pin trigger detection for the keypad wake block.
`timescale 1ns/1ps
`include "kwi_regs.svh"
module kwi_detect (
   input wire logic pclk,
   input wire logic presetn,
   kwi_det_if.det d
);
   kwi_pkg::kwi_pins_t act;
   kwi_pkg::kwi_pins_t prev_q;
   kwi_pkg::kwi_pins_t rise;

   // An enabled pin is asserted when its level matches the polarity.
   genvar i;
   generate
      for (i = 0; i < `KWI_NPINS; i++) begin : g_pin
         assign act[i] = d.pin_en[i] & ~(d.pin_in[i] ^ d.pol[i]);
         assign rise[i] = act[i] & ~prev_q[i];
      end
   endgenerate

   // Reset to asserted so a pin held active at reset is no edge.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_q <= `KWI_RST_PREV;
      end else begin
         prev_q <= act;
      end
   end

   // The edge compare is bypassed while stopped; levels alone wake.
   assign d.edge_any = (|rise) & ~d.stop;
   assign d.level_any = |act;
endmodule : kwi_detect

// File: rtl/kwi_top.sv
// Keypad wake interrupt block with an APB register slave.
`timescale 1ns/1ps
`include "kwi_regs.svh"
module kwi_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`KWI_ADDR_W-1:0] paddr,
   input wire logic [`KWI_DATA_W-1:0] pwdata,
   output logic [`KWI_DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [`KWI_NPINS-1:0] keypad_in,
   input wire logic [`KWI_NPINS-1:0] pullup_en,
   input wire logic stop_mode,
   input wire logic wait_mode,
   output logic [`KWI_NPINS-1:0] pin_pulldown,
   output logic [`KWI_NPINS-1:0] pin_pullup,
   output logic keypad_irq,
   output logic irq,
   output logic wake
);

   // Register state.
   // Bit 7 of both eight-bit registers has no flip-flop behind it.
   logic [`KWI_POL_MSB:`KWI_POL_LSB] trigger_polarity_q;
   kwi_pkg::kwi_pins_t pin_enable_q;
   logic irq_enable_q;
   logic detect_mode_q;
   logic pending_flag_q;
   logic pending_flag_d;
   logic [`KWI_IST_W-1:0] ist_q;
   logic [`KWI_IST_W-1:0] ist_d;
   logic [`KWI_IST_W-1:0] imsk_q;

   // Bus state.
   logic [`KWI_DATA_W-1:0] prdata_q;
   logic [`KWI_DATA_W-1:0] rdata_d;
   logic pready_q;
   logic pslverr_q;
   kwi_pkg::kwi_sel_t sel;
   logic xfer_done;
   logic wr_en;
   logic rd_done;
   logic ack_wr;

   // Pin side state.
   kwi_pkg::kwi_pins_t pol_eff;
   kwi_pkg::kwi_pins_t pulldown_q;
   kwi_pkg::kwi_pins_t pullup_q;
   logic keypad_irq_q;
   logic irq_q;
   logic wake_q;
   logic trig;
   logic wake_evt;

   // Wiring to the detector travels in one interface.
   kwi_det_if det_bus ();

   // Inputs 3:0 have no polarity control and stay falling/low.
   // Software cannot change these four, whatever it writes.
   assign pol_eff = {trigger_polarity_q, `KWI_FIXED_POL};

   // Hand the pins and the configuration to the detector.
   // The stop input bypasses the edge compare inside the detector.
   assign det_bus.pin_in = keypad_in;
   assign det_bus.pin_en = pin_enable_q;
   assign det_bus.pol = pol_eff;
   assign det_bus.stop = stop_mode;

   kwi_detect u_detect (
      .pclk(pclk),
      .presetn(presetn),
      .d(det_bus.det)
   );

   // APB slave with one wait state per transfer.
   // The wait state costs a cycle but keeps every bus output registered.

   // Address decode; anything not in the map answers with an error.
   // Only the low address byte is decoded; the map is four words.
   always_comb begin
      case (paddr)
         `KWI_OFF_SC: sel = kwi_pkg::KWI_SEL_SC;
         `KWI_OFF_PE: sel = kwi_pkg::KWI_SEL_PE;
         `KWI_OFF_IST: sel = kwi_pkg::KWI_SEL_IST;
         `KWI_OFF_IMSK: sel = kwi_pkg::KWI_SEL_IMSK;
         default: sel = kwi_pkg::KWI_SEL_NONE;
      endcase
   end

   // A transfer completes at the edge where pready is seen high.
   assign xfer_done = psel & penable & pready_q;
   assign wr_en = xfer_done & pwrite & ~pslverr_q;
   assign rd_done = xfer_done & ~pwrite;

   // Acknowledge is a write of one to its bit, never stored.
   assign ack_wr = wr_en & (sel == kwi_pkg::KWI_SEL_SC)
                   & pwdata[`KWI_ACK_BIT];

   // Read data; reserved bit 7 and the acknowledge bit read zero.
   always_comb begin
      rdata_d = `KWI_RST_DATA;
      unique case (sel)
         kwi_pkg::KWI_SEL_SC: begin
            rdata_d[`KWI_POL_MSB:`KWI_POL_LSB] = trigger_polarity_q;
            rdata_d[`KWI_PEND_BIT] = pending_flag_q;
            rdata_d[`KWI_ACK_BIT] = 1'b0;
            rdata_d[`KWI_IE_BIT] = irq_enable_q;
            rdata_d[`KWI_MODE_BIT] = detect_mode_q;
         end
         kwi_pkg::KWI_SEL_PE: begin
            rdata_d[`KWI_NPINS-1:0] = pin_enable_q;
         end
         kwi_pkg::KWI_SEL_IST: begin
            rdata_d[`KWI_IST_W-1:0] = ist_q;
         end
         kwi_pkg::KWI_SEL_IMSK: begin
            rdata_d[`KWI_IST_W-1:0] = imsk_q;
         end
         kwi_pkg::KWI_SEL_NONE: begin
            rdata_d = `KWI_RST_DATA;
         end
      endcase
   end

   // The answer comes one cycle into the access phase, so every
   // transfer is setup plus two access cycles; the wait state lets
   // pready and prdata leave flip-flops.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= `KWI_RST_DATA;
      end else begin
         pready_q <= psel & penable & ~pready_q;
         if (psel & penable & ~pready_q) begin
            pslverr_q <= (sel == kwi_pkg::KWI_SEL_NONE);
            prdata_q <= pwrite ? `KWI_RST_DATA : rdata_d;
         end else begin
            pslverr_q <= 1'b0;
         end
      end
   end

   // The bus outputs come straight from their flip-flops.
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;

   // Control registers, written only when a transfer completes.
   // Writes to an address that answers with an error never reach them.

   // Status/control writable fields: polarity, enable and mode.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trigger_polarity_q <= `KWI_RST_POL;
         irq_enable_q <= 1'b0;
         detect_mode_q <= 1'b0;
      end else if (wr_en && sel == kwi_pkg::KWI_SEL_SC) begin
         trigger_polarity_q <= pwdata[`KWI_POL_MSB:`KWI_POL_LSB];
         irq_enable_q <= pwdata[`KWI_IE_BIT];
         detect_mode_q <= pwdata[`KWI_MODE_BIT];
      end
   end

   // Pin enable register; bit 7 is not stored at all.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_enable_q <= `KWI_RST_PE;
      end else if (wr_en && sel == kwi_pkg::KWI_SEL_PE) begin
         pin_enable_q <= pwdata[`KWI_NPINS-1:0];
      end
   end

   // Interrupt mask register, same layout as the sticky status.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         imsk_q <= `KWI_RST_IST;
      end else if (wr_en && sel == kwi_pkg::KWI_SEL_IMSK) begin
         imsk_q <= pwdata[`KWI_IST_W-1:0];
      end
   end

   // Pending flag, set by triggers and cleared by acknowledge.
   // It is shared by all seven inputs, so software must poll the pins.

   // A trigger is an edge, or in stop mode any asserted level. In
   // edge-and-level mode an asserted level keeps setting the flag, so
   // an acknowledge cannot clear it while a key is still held.
   assign trig = det_bus.edge_any
                 | (stop_mode & det_bus.level_any)
                 | (detect_mode_q & det_bus.level_any);

   // A trigger in the acknowledge cycle wins over the clear.
   always_comb begin
      pending_flag_d = pending_flag_q;
      if (ack_wr) begin
         pending_flag_d = 1'b0;
      end
      if (trig) begin
         pending_flag_d = 1'b1;
      end
   end

   // The flag flip-flop; a trigger shows in a read one edge later.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pending_flag_q <= 1'b0;
      end else begin
         pending_flag_q <= pending_flag_d;
      end
   end

   // Sticky event status, cleared by reading it.
   // It records wakes too, which the pending flag cannot tell apart.

   // Only the bits returned by the read are cleared, so an event that
   // lands during the read's wait state survives to the next read.
   assign wake_evt = (stop_mode | wait_mode) & trig;

   // A new event is applied last, so it wins over a read clear.
   always_comb begin
      ist_d = ist_q;
      if (rd_done && sel == kwi_pkg::KWI_SEL_IST) begin
         ist_d = ist_q & ~prdata_q[`KWI_IST_W-1:0];
      end
      if (trig) begin
         ist_d[`KWI_IST_PEND] = 1'b1;
      end
      if (wake_evt) begin
         ist_d[`KWI_IST_WAKE] = 1'b1;
      end
   end

   // Status flip-flops.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ist_q <= `KWI_RST_IST;
      end else begin
         ist_q <= ist_d;
      end
   end

   // Outputs to the processor and the power controller.
   // All are registered, so each lags its cause by one edge.

   // The keypad request follows the flag only when enabled; with the
   // enable low software still polls the flag.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         keypad_irq_q <= 1'b0;
      end else begin
         keypad_irq_q <= irq_enable_q & pending_flag_d;
      end
   end

   // System interrupt: any unmasked sticky status bit.
   // It uses the next status so it rises with the status bit itself.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(ist_d & imsk_q);
      end
   end

   // Wake request stays up while a low-power mode is requested and
   // the flag is set, until software acknowledges it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_q <= 1'b0;
      end else begin
         wake_q <= (stop_mode | wait_mode) & pending_flag_d;
      end
   end

   // Drive the outputs from the flip-flops above.
   assign keypad_irq = keypad_irq_q;
   assign irq = irq_q;
   assign wake = wake_q;

   // Pad pull selection.
   // The pulls are registered and so follow a configuration write late.

   // A rising-polarity keypad pin needs a pulldown so that its idle
   // level is the deasserted one; the port's pull request is reused.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulldown_q <= `KWI_RST_PE;
         pullup_q <= `KWI_RST_PE;
      end else begin
         pulldown_q <= pullup_en & pin_enable_q & pol_eff;
         pullup_q <= pullup_en & ~(pin_enable_q & pol_eff);
      end
   end

   // Pull requests leave their flip-flops untouched.
   assign pin_pulldown = pulldown_q;
   assign pin_pullup = pullup_q;

endmodule : kwi_top

// File: tb/kwi_sva.sv
// Port-level checks of the keypad wake block.
`timescale 1ns/1ps
`include "kwi_regs.svh"
module kwi_sva (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`KWI_ADDR_W-1:0] paddr,
   input wire logic [`KWI_DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [`KWI_NPINS-1:0] pullup_en,
   input wire logic stop_mode,
   input wire logic wait_mode,
   input wire logic [`KWI_NPINS-1:0] pin_pulldown,
   input wire logic [`KWI_NPINS-1:0] pin_pullup,
   input wire logic wake
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Only the four documented offsets answer without an error.
   logic mapped;
   logic rd_done;
   assign mapped = paddr inside {`KWI_OFF_SC, `KWI_OFF_PE, `KWI_OFF_IST,
                                 `KWI_OFF_IMSK};
   assign rd_done = pready && psel && penable && !pwrite;

   // A transfer is a setup cycle followed by the answer two edges later.
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence answer_s;
      ##2 (pready && psel && penable);
   endsequence

   ans_timing_a: assert property (setup_s |-> answer_s)
      else $error("answer did not come two cycles after setup");
   pready_pulse_a: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   pready_qual_a: assert property (pready |-> psel && penable)
      else $error("pready outside an access phase");
   err_decode_a: assert property (pready |-> pslverr == !mapped)
      else $error("pslverr does not match the address decode");
   sc_reserved_a: assert property (
      rd_done && paddr == `KWI_OFF_SC |-> prdata[31:7] == 0 && !prdata[2])
      else $error("reserved or acknowledge bit read back nonzero");
   pe_reserved_a: assert property (
      rd_done && paddr == `KWI_OFF_PE |-> prdata[31:7] == 0)
      else $error("pin enable reserved bits read back nonzero");
   pull_excl_a: assert property ((pin_pulldown & pin_pullup) == 0)
      else $error("pullup and pulldown both on");
   pull_cause_a: assert property (
      (pin_pulldown & ~$past(pullup_en)) == 0)
      else $error("pulldown on a pin with its pull disabled");
   wake_cause_a: assert property (wake |-> $past(stop_mode || wait_mode))
      else $error("wake outside a low-power mode");
endmodule : kwi_sva

// File: tb/kwi_keypad_model.sv
// Keypad switch model driving the shared keypad pins.
`timescale 1ns/1ps
module kwi_keypad_model (
   input wire logic [6:0] press,
   input wire logic [6:0] press_lvl,
   input wire logic [6:0] pin_pulldown,
   output logic [6:0] keypad_in
);
   // A released switch leaves the pin at its pull, the deasserted level.
   // Pins with no pull read high; the bench always enables the pulls.
   assign keypad_in = (press & press_lvl) | (~press & ~pin_pulldown);
endmodule : kwi_keypad_model

// File: tb/tb.sv
// Self-checking bench for the keypad wake block.
`timescale 1ns/1ps
`include "kwi_regs.svh"
module tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [6:0] keypad_in;
   logic [6:0] pullup_en = 7'h7f;
   logic stop_mode = 1'b0;
   logic wait_mode = 1'b0;
   logic [6:0] pin_pulldown;
   logic [6:0] pin_pullup;
   logic keypad_irq;
   logic irq;
   logic wake;
   logic [6:0] press = 7'h00;
   logic [6:0] press_lvl = 7'h00;
   logic last_err;
   int fails = 0;
   int checked = 0;

   // Half period of 10 ns gives the 50 MHz bus clock.
   always #10 pclk = ~pclk;

   kwi_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .keypad_in(keypad_in), .pullup_en(pullup_en), .stop_mode(stop_mode),
      .wait_mode(wait_mode), .pin_pulldown(pin_pulldown),
      .pin_pullup(pin_pullup), .keypad_irq(keypad_irq), .irq(irq),
      .wake(wake));
   kwi_keypad_model keys (.press(press), .press_lvl(press_lvl),
      .pin_pulldown(pin_pulldown), .keypad_in(keypad_in));

   task automatic report_and_stop();
      $display("fails=%0d checked=%0d", fails, checked);
      if (fails == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Settle one step past the edge so registered outputs have landed.
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask : cyc

   // One APB transfer; the wait for pready is bounded.
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         fails++;
         report_and_stop();
      end
      q = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask : wr

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      apb(1'b0, a, 32'h0000_0000, q);
      chk(q, exp);
   endtask : rchk

   task automatic keys_set(input logic [6:0] p, input logic [6:0] l);
      @(posedge pclk);
      press <= p;
      press_lvl <= l;
      cyc(3);
   endtask : keys_set

   // Enabling a pin can itself look like an edge, so acknowledge after.
   task automatic arm(input logic [7:0] sc, input logic [7:0] pe);
      wr(`KWI_OFF_PE, {24'h0, pe});
      wr(`KWI_OFF_SC, {24'h0, sc});
      cyc(3);
      wr(`KWI_OFF_SC, {24'h0, sc | 8'h04});
      cyc(2);
      rchk(`KWI_OFF_SC, {24'h0, sc});
   endtask : arm

   task automatic t_reset_regs();
      rchk(`KWI_OFF_SC, 32'h0000_0000);
      rchk(`KWI_OFF_PE, 32'h0000_0000);
      rchk(`KWI_OFF_IST, 32'h0000_0000);
      rchk(`KWI_OFF_IMSK, 32'h0000_0000);
      rchk(8'h10, 32'h0000_0000);
      chk({31'h0, last_err}, 32'h0000_0001);
      wr(`KWI_OFF_SC, 32'hffff_ffff);
      rchk(`KWI_OFF_SC, 32'h0000_0073);
      wr(`KWI_OFF_PE, 32'hffff_ffff);
      rchk(`KWI_OFF_PE, 32'h0000_007f);
   endtask : t_reset_regs

   task automatic t_fixed_fall();
      wr(`KWI_OFF_IMSK, 32'h0000_0000);
      arm(8'h72, 8'h09);
      keys_set(7'h08, 7'h00);
      chk({31'h0, keypad_irq}, 32'h0000_0001);
      chk({31'h0, irq}, 32'h0000_0000);
      rchk(`KWI_OFF_SC, 32'h0000_007a);
      wr(`KWI_OFF_SC, 32'h0000_0076);
      cyc(2);
      rchk(`KWI_OFF_SC, 32'h0000_0072);
      chk({31'h0, keypad_irq}, 32'h0000_0000);
      keys_set(7'h00, 7'h00);
   endtask : t_fixed_fall

   task automatic t_disabled();
      arm(8'h02, 8'h01);
      keys_set(7'h02, 7'h00);
      rchk(`KWI_OFF_SC, 32'h0000_0002);
      keys_set(7'h00, 7'h00);
   endtask : t_disabled

   task automatic t_rising();
      arm(8'h12, 8'h10);
      chk({25'h0, pin_pulldown}, 32'h0000_0010);
      chk({25'h0, pin_pullup}, 32'h0000_006f);
      keys_set(7'h10, 7'h10);
      rchk(`KWI_OFF_SC, 32'h0000_001a);
      keys_set(7'h00, 7'h00);
   endtask : t_rising

   task automatic t_level();
      arm(8'h03, 8'h01);
      keys_set(7'h01, 7'h00);
      wr(`KWI_OFF_SC, 32'h0000_0007);
      cyc(2);
      rchk(`KWI_OFF_SC, 32'h0000_000b);
      keys_set(7'h00, 7'h00);
      wr(`KWI_OFF_SC, 32'h0000_0007);
      cyc(2);
      rchk(`KWI_OFF_SC, 32'h0000_0003);
   endtask : t_level

   task automatic t_status_irq();
      arm(8'h00, 8'h01);
      rchk(`KWI_OFF_IST, 32'h0000_0001);
      wr(`KWI_OFF_IMSK, 32'h0000_0001);
      keys_set(7'h01, 7'h00);
      chk({31'h0, irq}, 32'h0000_0001);
      chk({31'h0, keypad_irq}, 32'h0000_0000);
      rchk(`KWI_OFF_IST, 32'h0000_0001);
      cyc(2);
      chk({31'h0, irq}, 32'h0000_0000);
      keys_set(7'h00, 7'h00);
   endtask : t_status_irq

   task automatic t_wake();
      arm(8'h00, 8'h01);
      @(posedge pclk);
      wait_mode <= 1'b1;
      keys_set(7'h01, 7'h00);
      chk({31'h0, wake}, 32'h0000_0001);
      @(posedge pclk);
      wait_mode <= 1'b0;
      stop_mode <= 1'b1;
      wr(`KWI_OFF_SC, 32'h0000_0004);
      cyc(2);
      rchk(`KWI_OFF_SC, 32'h0000_0008);
      chk({31'h0, wake}, 32'h0000_0001);
      rchk(`KWI_OFF_IST, 32'h0000_0003);
      keys_set(7'h00, 7'h00);
      @(posedge pclk);
      stop_mode <= 1'b0;
      wr(`KWI_OFF_SC, 32'h0000_0004);
      cyc(2);
      chk({31'h0, wake}, 32'h0000_0000);
      rchk(`KWI_OFF_SC, 32'h0000_0000);
   endtask : t_wake

   // Reset for sixteen cycles, then run every scenario once.
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      cyc(2);
      t_reset_regs();
      t_fixed_fall();
      t_disabled();
      t_rising();
      t_level();
      t_status_irq();
      t_wake();
      report_and_stop();
   end
endmodule : tb

bind kwi_top kwi_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .pullup_en(pullup_en),
   .stop_mode(stop_mode), .wait_mode(wait_mode),
   .pin_pulldown(pin_pulldown), .pin_pullup(pin_pullup), .wake(wake));
